// ### hdl/gsc_regs.sv
// gauge status, sleep policy and special-feature registers behind a
// two-wire slave
//
// Functional notes
// [RULE1] set charge-full after qualified full window
// [RULE2] clear charge-full when active capacity below 90%
// [RULE3] active-empty: set low voltage, clear above 5%
// [RULE4] standby-empty: set below 10%, clear above 15%
// [RULE5] learn set on voltage falling with discharge
// [RULE6] learn clear: full, low current, load, sleep
// [RULE7] learn clear at zero charge after empty
// [RULE8] upper four flags read-only to host
// [RULE9] undervoltage flag set below sleep voltage
// [RULE10] power-on reset flag set at power-up
// [RULE11] host write alone clears undervoltage, reset flags
// [RULE12] sleep policy loaded from nonvolatile copy
// [RULE13] undervoltage sleep needs stable bus lines
// [RULE14] bus-idle sleep needs both lines low
// [RULE15] slave address writes gated, gate resets zero
// [RULE16] pin control zero drives pin low
// [RULE17] pin control reads sensed pin level
// [RULE18] pin control one at reset and sleep
// [RULE19] host enables address writes before writing
// [RULE20] reserved bits ignore writes, read zero

`timescale 1ns/1ps
`default_nettype none

module gsc_regs #(
  parameter int unsigned SLEEP_DELAY_CYCLES = gsc_pkg::SLEEP_DELAY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // general purpose open-drain pin
  input wire logic general_purpose_pin_in,
  output logic general_purpose_pin_out,
  output logic general_purpose_pin_oe,
  // measurement engine and nonvolatile copy
  input wire gsc_pkg::gsc_meas_type meas,
  input wire logic [7:0] sleep_policy_nv,
  // device state
  output logic sleep,
  output logic [6:0] slave_address
);
  import gsc_pkg::*;

  localparam logic [SLEEP_CNT_W-1:0] SLEEP_LIMIT =
    SLEEP_CNT_W'(SLEEP_DELAY_CYCLES);

  logic scl_prev_reg, sda_prev_reg;
  logic start_cond, stop_cond, scl_rise, scl_fall, bus_change;
  gsc_bus_state_type state_reg;
  logic [7:0] shift_reg, ptr_reg;
  logic [3:0] bit_cnt_reg;
  logic rw_reg, sda_oe_reg;
  logic bus_wr, byte_end;
  logic [7:0] rd_data;

  logic charge_full_reg, active_empty_reg, standby_empty_reg, learn_reg;
  logic undervoltage_reg, power_on_reset_reg;
  logic [1:0] sleep_policy_reg;
  logic policy_loaded_reg;
  logic slave_address_write_reg, pin_drive_reg;
  logic [6:0] slave_address_reg;
  logic sleep_reg, enter_sleep;
  logic [SLEEP_CNT_W-1:0] stable_cnt_reg, low_cnt_reg;

  logic measured_voltage_above_chg_reg, average_current_ok_prev_reg, average_current_ok;
  logic measured_voltage_above_ae_reg, empty_armed_reg;
  logic full_set, learn_set, learn_clear, below_ae, discharge_ok;
  logic wr_flags, wr_feature, wr_policy, wr_address;

  // inputs are already synchronous, so one stage suffices for edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_prev_reg;
  assign scl_fall = ~scl_in & scl_prev_reg;
  assign start_cond = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign stop_cond = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
  assign bus_change = (scl_in != scl_prev_reg) | (sda_in != sda_prev_reg);
  assign byte_end = scl_fall & (bit_cnt_reg == BITS_PER_BYTE);
  assign bus_wr = (state_reg == GSC_WDATA) & byte_end;

  assign wr_flags = bus_wr & (ptr_reg == GAUGE_FLAGS_ADDR); // [RULE8]
  assign wr_feature = bus_wr & (ptr_reg == FEATURE_PIN_AND_ADDR_ENABLE_ADDR);
  assign wr_policy = bus_wr & (ptr_reg == SLEEP_POLICY_ADDR);
  assign wr_address = bus_wr & (ptr_reg == SLAVE_ADDRESS_ADDR);

  // read view; unlisted locations and reserved bits read zero
  always_comb begin
    rd_data = 8'h00; // [RULE20]
    case (ptr_reg)
      GAUGE_FLAGS_ADDR: begin
        rd_data[CHARGE_FULL_BIT] = charge_full_reg;
        rd_data[ACTIVE_EMPTY_BIT] = active_empty_reg;
        rd_data[STANDBY_EMPTY_BIT] = standby_empty_reg;
        rd_data[LEARN_BIT] = learn_reg;
        rd_data[UNDERVOLTAGE_BIT] = undervoltage_reg;
        rd_data[POWER_ON_RESET_BIT] = power_on_reset_reg;
      end
      FEATURE_PIN_AND_ADDR_ENABLE_ADDR: begin
        rd_data[SLAVE_ADDRESS_WRITE_BIT] = slave_address_write_reg;
        rd_data[PIN_SENSE_CONTROL_BIT] = general_purpose_pin_in; // [RULE17]
      end
      SLEEP_POLICY_ADDR: begin
        rd_data[UNDERVOLTAGE_SLEEP_BIT] = sleep_policy_reg[1];
        rd_data[BUS_IDLE_SLEEP_BIT] = sleep_policy_reg[0];
      end
      SLAVE_ADDRESS_ADDR: rd_data = {slave_address_reg, 1'b0};
      default: rd_data = 8'h00;
    endcase
  end

  // two-wire slave: address byte, pointer byte, then data bytes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= GSC_IDLE;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= GSC_ADDR;
      bit_cnt_reg <= 4'h0;
    end else if (stop_cond) begin
      state_reg <= GSC_IDLE;
    end else begin
      case (state_reg)
        GSC_ADDR, GSC_PTR, GSC_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_in};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == GSC_ADDR) begin
              rw_reg <= shift_reg[0];
              state_reg <= (shift_reg[7:1] == slave_address_reg) ?
                GSC_ACK_ADDR : GSC_IDLE;
            end else if (state_reg == GSC_PTR) begin
              ptr_reg <= shift_reg;
              state_reg <= GSC_ACK_PTR;
            end else begin
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= GSC_ACK_WDATA;
            end
          end
        end
        GSC_ACK_ADDR, GSC_RACK: begin
          if (state_reg == GSC_RACK && scl_rise && sda_in) begin
            state_reg <= GSC_IDLE;
          end else if (scl_fall) begin
            if (rw_reg) begin
              shift_reg <= rd_data;
              ptr_reg <= ptr_reg + 8'h01;
              bit_cnt_reg <= 4'h0;
              state_reg <= GSC_RDATA;
            end else begin
              state_reg <= GSC_PTR;
            end
          end
        end
        GSC_ACK_PTR, GSC_ACK_WDATA: begin
          if (scl_fall) begin
            state_reg <= GSC_WDATA;
          end
        end
        GSC_RDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            state_reg <= GSC_RACK;
          end else if (scl_fall) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
        end
        default: state_reg <= GSC_IDLE;
      endcase
    end
  end

  // registered so the data line never glitches on a decode change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= (state_reg == GSC_ACK_ADDR) ||
        (state_reg == GSC_ACK_PTR) || (state_reg == GSC_ACK_WDATA) ||
        ((state_reg == GSC_RDATA) && !shift_reg[7]);
    end
  end

  assign sda_oe = sda_oe_reg;
  assign sda_out = 1'b0;

  // full detect window between two average-current updates
  assign average_current_ok = (meas.average_current > 16'sh0000) &&
    (meas.average_current < meas.minimum_charge_current);
  assign full_set = meas.average_current_update & average_current_ok &
    average_current_ok_prev_reg & measured_voltage_above_chg_reg &
    (meas.measured_voltage > meas.charge_voltage_threshold);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      measured_voltage_above_chg_reg <= 1'b0;
      average_current_ok_prev_reg <= 1'b0;
    end else if (meas.average_current_update) begin
      measured_voltage_above_chg_reg <=
        meas.measured_voltage > meas.charge_voltage_threshold;
      average_current_ok_prev_reg <= average_current_ok;
    end else if (meas.measured_voltage <= meas.charge_voltage_threshold) begin
      measured_voltage_above_chg_reg <= 1'b0;
    end
  end

  // set has priority over clear in every flag below
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      charge_full_reg <= 1'b0;
    end else if (full_set) begin
      charge_full_reg <= 1'b1; // [RULE1]
    end else if (meas.remaining_active_relative_capacity <
                 CHARGE_FULL_CLEAR_PCT) begin
      charge_full_reg <= 1'b0; // [RULE2]
    end
  end

  assign below_ae = meas.measured_voltage < meas.active_empty_voltage;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_empty_reg <= 1'b0;
    end else if (below_ae) begin
      active_empty_reg <= 1'b1; // [RULE3]
    end else if (meas.remaining_active_relative_capacity >
                 ACTIVE_EMPTY_CLEAR_PCT) begin
      active_empty_reg <= 1'b0; // [RULE3]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby_empty_reg <= 1'b0;
    end else if (meas.remaining_standby_relative_capacity <
                 STANDBY_EMPTY_SET_PCT) begin
      standby_empty_reg <= 1'b1; // [RULE4]
    end else if (meas.remaining_standby_relative_capacity >
                 STANDBY_EMPTY_CLEAR_PCT) begin
      standby_empty_reg <= 1'b0; // [RULE4]
    end
  end

  // learn cycle start: falling edge through the empty voltage
  assign discharge_ok = (meas.current < 16'sh0000) &&
    ((-meas.current) > meas.active_empty_current);
  assign learn_set = measured_voltage_above_ae_reg & below_ae & discharge_ok; // [RULE5]
  assign learn_clear = full_set | charge_full_reg |
    (meas.current < LEARN_CLEAR_CURRENT) |
    meas.accumulated_charge_loaded | enter_sleep | // [RULE6]
    (empty_armed_reg & (meas.accumulated_charge == 16'h0000)); // [RULE7]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      measured_voltage_above_ae_reg <= 1'b0;
      empty_armed_reg <= 1'b0;
    end else begin
      measured_voltage_above_ae_reg <= ~below_ae;
      if (below_ae) begin
        empty_armed_reg <= 1'b1;
      end else if (charge_full_reg) begin
        empty_armed_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      learn_reg <= 1'b0;
    end else if (learn_set) begin
      learn_reg <= 1'b1;
    end else if (learn_clear) begin
      learn_reg <= 1'b0;
    end
  end

  // host writes only clear these two; a hardware set still wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      undervoltage_reg <= 1'b0;
    end else if (meas.measured_voltage < meas.sleep_voltage_threshold) begin
      undervoltage_reg <= 1'b1; // [RULE9]
    end else if (wr_flags && !shift_reg[UNDERVOLTAGE_BIT]) begin
      undervoltage_reg <= 1'b0; // [RULE11]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_on_reset_reg <= POWER_ON_RESET_FLAG_RESET; // [RULE10]
    end else if (wr_flags && !shift_reg[POWER_ON_RESET_BIT]) begin
      power_on_reset_reg <= 1'b0; // [RULE11]
    end
  end

  // nonvolatile default is taken on the first edge after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      policy_loaded_reg <= 1'b0;
      sleep_policy_reg <= 2'b00;
    end else if (!policy_loaded_reg) begin
      policy_loaded_reg <= 1'b1;
      sleep_policy_reg <= {sleep_policy_nv[UNDERVOLTAGE_SLEEP_BIT],
                           sleep_policy_nv[BUS_IDLE_SLEEP_BIT]}; // [RULE12]
    end else if (wr_policy) begin
      sleep_policy_reg <= {shift_reg[UNDERVOLTAGE_SLEEP_BIT],
                           shift_reg[BUS_IDLE_SLEEP_BIT]}; // [RULE12]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slave_address_write_reg <= SLAVE_ADDRESS_WRITE_RESET; // [RULE15]
    end else if (wr_feature) begin
      slave_address_write_reg <= shift_reg[SLAVE_ADDRESS_WRITE_BIT];
    end
  end

  // sleep forces the pin released even if a write lands together
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_drive_reg <= PIN_SENSE_CONTROL_RESET; // [RULE18]
    end else if (enter_sleep) begin
      pin_drive_reg <= PIN_SENSE_CONTROL_RESET; // [RULE18]
    end else if (wr_feature) begin
      pin_drive_reg <= shift_reg[PIN_SENSE_CONTROL_BIT]; // [RULE16]
    end
  end

  assign general_purpose_pin_out = 1'b0;
  assign general_purpose_pin_oe = ~pin_drive_reg; // [RULE16]

  // new address applies from the next transaction onward
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slave_address_reg <= SLAVE_ADDRESS_RESET;
    end else if (wr_address && slave_address_write_reg) begin
      slave_address_reg <= shift_reg[7:1]; // [RULE15] [RULE19]
    end
  end

  assign slave_address = slave_address_reg;

  // bus quiet counters saturate at the delay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stable_cnt_reg <= '0;
    end else if (bus_change) begin
      stable_cnt_reg <= '0;
    end else if (stable_cnt_reg < SLEEP_LIMIT) begin
      stable_cnt_reg <= stable_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_reg <= '0;
    end else if (scl_in || sda_in) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg < SLEEP_LIMIT) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  assign enter_sleep = ~sleep_reg & (
    (sleep_policy_reg[1] &
     (meas.input_voltage < meas.sleep_voltage_threshold) &
     (stable_cnt_reg >= SLEEP_LIMIT)) | // [RULE13]
    (sleep_policy_reg[0] & (low_cnt_reg >= SLEEP_LIMIT))); // [RULE14]

  // any bus line movement wakes the device
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_reg <= 1'b0;
    end else if (enter_sleep) begin
      sleep_reg <= 1'b1;
    end else if (bus_change) begin
      sleep_reg <= 1'b0;
    end
  end

  assign sleep = sleep_reg;

endmodule : gsc_regs

`default_nettype wire

// ### include/gsc_pkg.sv
// constants and types shared by the gauge status and control registers
package gsc_pkg;

  // register locations on the two-wire bus
  localparam logic [7:0] GAUGE_FLAGS_ADDR = 8'h01;
  localparam logic [7:0] FEATURE_PIN_AND_ADDR_ENABLE_ADDR = 8'h15;
  localparam logic [7:0] SLEEP_POLICY_ADDR = 8'h60;
  localparam logic [7:0] SLAVE_ADDRESS_ADDR = 8'h7e;

  // gauge_flags fields
  localparam int CHARGE_FULL_BIT = 7;
  localparam int ACTIVE_EMPTY_BIT = 6;
  localparam int STANDBY_EMPTY_BIT = 5;
  localparam int LEARN_BIT = 4;
  localparam int UNDERVOLTAGE_BIT = 2;
  localparam int POWER_ON_RESET_BIT = 1;

  // sleep_policy fields
  localparam int UNDERVOLTAGE_SLEEP_BIT = 6;
  localparam int BUS_IDLE_SLEEP_BIT = 5;

  // feature_pin_and_addr_enable fields and reset values, plus power-on reset flag and slave address resets
  localparam int SLAVE_ADDRESS_WRITE_BIT = 1;
  localparam int PIN_SENSE_CONTROL_BIT = 0;
  localparam logic SLAVE_ADDRESS_WRITE_RESET = 1'b0;
  localparam logic PIN_SENSE_CONTROL_RESET = 1'b1;
  localparam logic POWER_ON_RESET_FLAG_RESET = 1'b1;
  localparam logic [6:0] SLAVE_ADDRESS_RESET = 7'h34;

  // relative capacity thresholds in percent
  localparam logic [7:0] CHARGE_FULL_CLEAR_PCT = 8'h5a;
  localparam logic [7:0] ACTIVE_EMPTY_CLEAR_PCT = 8'h05;
  localparam logic [7:0] STANDBY_EMPTY_SET_PCT = 8'h0a;
  localparam logic [7:0] STANDBY_EMPTY_CLEAR_PCT = 8'h0f;

  // current level that ends a learn cycle, in current-result lsbs
  localparam logic signed [15:0] LEARN_CLEAR_CURRENT = 16'sh0040;

  // bus sleep delay
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_DELAY_US = 2000;
  localparam int SLEEP_DELAY_CYC = (SLEEP_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int SLEEP_CNT_W = 24;

  // two-wire receiver
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    GSC_IDLE, GSC_ADDR, GSC_ACK_ADDR, GSC_PTR, GSC_ACK_PTR,
    GSC_WDATA, GSC_ACK_WDATA, GSC_RDATA, GSC_RACK
  } gsc_bus_state_type;

  // results delivered by the measurement engine
  typedef struct packed {
    logic [15:0] measured_voltage;
    logic [15:0] charge_voltage_threshold;
    logic [15:0] active_empty_voltage;
    logic [15:0] sleep_voltage_threshold;
    logic [15:0] input_voltage;
    logic signed [15:0] current;
    logic signed [15:0] average_current;
    logic signed [15:0] minimum_charge_current;
    logic signed [15:0] active_empty_current;
    logic [7:0] remaining_active_relative_capacity;
    logic [7:0] remaining_standby_relative_capacity;
    logic [15:0] accumulated_charge;
    logic average_current_update;
    logic accumulated_charge_loaded;
  } gsc_meas_type;

endpackage : gsc_pkg

// ### verif/gsc_regs_monitor.sv
// port-level checks for the gauge status and control registers
`timescale 1ns/1ps
`default_nettype none

module gsc_regs_monitor #(
  parameter int unsigned SLEEP_DELAY_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // two-wire lines
  input wire logic scl_in,
  input wire logic sda_in,
  // pin and device state
  input wire logic general_purpose_pin_out,
  input wire logic general_purpose_pin_oe,
  input wire logic sleep,
  input wire logic [6:0] slave_address
);
  import gsc_pkg::*;

  logic scl_q;
  logic sda_q;
  logic [31:0] quiet_cnt;

  // clocks with both lines unchanged; a little slack for input sampling
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      quiet_cnt <= '0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (scl_in != scl_q || sda_in != sda_q) begin
        quiet_cnt <= '0;
      end else begin
        quiet_cnt <= quiet_cnt + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  reset_pin_a: assert property ($rose(rstn) |->
    !general_purpose_pin_oe && !sleep)
    else $error("pin driven or asleep after reset");
  addr_reset_a: assert property ($rose(rstn) |->
    slave_address == SLAVE_ADDRESS_RESET)
    else $error("slave address wrong after reset");
  addr_write_a: assert property ($changed(slave_address) |->
    !scl_in)
    else $error("slave address moved outside a write");
  sleep_pin_a: assert property ($rose(sleep) |->
    ##[0:1] !general_purpose_pin_oe)
    else $error("pin still driven in sleep");
  sleep_delay_a: assert property ($rose(sleep) |->
    quiet_cnt >= SLEEP_DELAY_CYCLES - 2)
    else $error("sleep entered before the delay");
  sleep_wake_a: assert property (sleep &&
    (scl_in != scl_q || sda_in != sda_q) |-> ##[1:2] !sleep)
    else $error("no wake on bus activity");
  pin_drive_a: assert property (general_purpose_pin_oe |->
    !general_purpose_pin_out && !sleep)
    else $error("pin driven high or driven in sleep");
  pin_hold_a: assert property ($changed(general_purpose_pin_oe) |->
    !scl_in || sleep)
    else $error("pin drive moved outside a write or sleep");
endmodule : gsc_regs_monitor

bind gsc_regs gsc_regs_monitor #(.SLEEP_DELAY_CYCLES(SLEEP_DELAY_CYCLES)) mon (
  .clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
  .general_purpose_pin_out(general_purpose_pin_out),
  .general_purpose_pin_oe(general_purpose_pin_oe),
  .sleep(sleep), .slave_address(slave_address));

`default_nettype wire

// ### verif/gsc_host.sv
// two-wire bus host model that reaches the register block
`timescale 1ns/1ps
`default_nettype none

module gsc_host (
  // clock
  input wire logic clk,
  // two-wire lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  import gsc_pkg::*;

  logic [6:0] addr = SLAVE_ADDRESS_RESET; // moved only after 7Eh

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // sda only moves while scl is low, so no stray start or stop
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    wt(3);
    scl <= 1'b1;
    wt(3);
    r = sda;
    scl <= 1'b0;
    wt(3);
  endtask : bitx

  task automatic byte_x(input logic [7:0] d, input logic ab,
                        output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(ab, a);
  endtask : byte_x

  task automatic start;
    sda_low <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sda_low <= 1'b1;
    wt(3);
    scl <= 1'b0;
    wt(3);
  endtask : start

  task automatic stop;
    sda_low <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sda_low <= 1'b0;
    wt(3);
  endtask : stop

  task automatic wr(input logic [7:0] p, d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    byte_x({addr, 1'b0}, 1'b1, q, a0);
    byte_x(p, 1'b1, q, a1);
    byte_x(d, 1'b1, q, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask : wr

  // repeated start; the final nack ends the read
  task automatic rd(input logic [7:0] p, output logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    byte_x({addr, 1'b0}, 1'b1, q, a0);
    byte_x(p, 1'b1, q, a1);
    start();
    byte_x({addr, 1'b1}, 1'b1, q, a2);
    byte_x(8'hff, 1'b1, d, a3);
    stop();
    ok = !(a0 | a1 | a2);
  endtask : rd

  // both lines low, entered without forming a start
  task automatic park;
    scl <= 1'b0;
    wt(2);
    sda_low <= 1'b1;
    wt(2);
  endtask : park

  task automatic unpark;
    sda_low <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
  endtask : unpark
endmodule : gsc_host

`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the gauge status and control registers
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import gsc_pkg::*;

  localparam int unsigned DLY = 20;
  localparam logic [7:0] GA = GAUGE_FLAGS_ADDR;
  localparam logic [7:0] FA = FEATURE_PIN_AND_ADDR_ENABLE_ADDR;
  localparam logic [7:0] PA = SLEEP_POLICY_ADDR;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scl, sda_low, sda, sda_out, sda_oe, ok;
  logic gp_pu = 1'b0;
  logic gp_in, gp_out, gp_oe, sleep;
  logic [6:0] slave_address;
  logic [7:0] nv = 8'hff;
  logic [7:0] rv;
  gsc_meas_type m;
  int err_count = 0;
  int compares = 0;

  // pull-up on sda; the pin has a weak pulldown unless gp_pu pulls it up
  assign sda = !(sda_low || sda_oe);
  assign gp_in = !gp_oe && gp_pu;

  gsc_regs #(.SLEEP_DELAY_CYCLES(DLY)) dut (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .general_purpose_pin_in(gp_in),
    .general_purpose_pin_out(gp_out), .general_purpose_pin_oe(gp_oe),
    .meas(m), .sleep_policy_nv(nv), .sleep(sleep),
    .slave_address(slave_address));
  gsc_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  initial forever #5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic w(input logic [7:0] a, d);
    host.wr(a, d, ok);
    check({7'h0, ok}, 8'h01);
  endtask : w

  task automatic rchk(input logic [7:0] a, exp);
    host.rd(a, rv, ok);
    check({7'h0, ok}, 8'h01);
    check(rv, exp);
  endtask : rchk

  task automatic upd;
    @(posedge clk);
    m.average_current_update <= 1'b1;
    @(posedge clk);
    m.average_current_update <= 1'b0;
    tick(2);
  endtask : upd

  task automatic wait_sleep;
    int n;
    n = 0;
    while (sleep !== 1'b1 && n < 4 * DLY) begin
      @(posedge clk);
      n++;
    end
    check({7'h0, sleep}, 8'h01);
  endtask : wait_sleep

  task automatic t_reset;
    rchk(GA, 8'h02);
    rchk(PA, 8'h60);
    rchk(FA, 8'h00);
  endtask : t_reset

  task automatic t_status;
    m.measured_voltage <= 16'h0300;
    tick(3);
    m.measured_voltage <= 16'h1000;
    rchk(GA, 8'h06);
    w(GA, 8'hfe);
    rchk(GA, 8'h06);
    w(GA, 8'h00);
    rchk(GA, 8'h00);
  endtask : t_status

  // voltage falls with no discharge, so learn must stay clear
  task automatic t_empty;
    m.remaining_active_relative_capacity <= 8'h05;
    m.remaining_standby_relative_capacity <= 8'h09;
    m.measured_voltage <= 16'h0100;
    tick(3);
    m.measured_voltage <= 16'h1000;
    m.remaining_standby_relative_capacity <= 8'h0f;
    rchk(GA, 8'h64);
    m.remaining_active_relative_capacity <= 8'h06;
    m.remaining_standby_relative_capacity <= 8'h10;
    rchk(GA, 8'h04);
    w(GA, 8'h00);
  endtask : t_empty

  task automatic t_full;
    m.remaining_active_relative_capacity <= 8'h5f;
    m.measured_voltage <= 16'h2100;
    m.average_current <= 16'sh0050;
    upd();
    rchk(GA, 8'h00);
    upd();
    rchk(GA, 8'h80);
    m.remaining_active_relative_capacity <= 8'h59;
    rchk(GA, 8'h00);
    m.remaining_active_relative_capacity <= 8'h5f;
    m.average_current <= 16'sh0000;
    upd();
    upd();
    rchk(GA, 8'h00);
    m.measured_voltage <= 16'h1000;
  endtask : t_full

  // charge current follows at once, so only the chosen clear ends learn
  task automatic t_learn;
    m.remaining_active_relative_capacity <= 8'h05;
    for (int i = 0; i < 3; i++) begin
      m.current <= -16'sh0100;
      m.accumulated_charge <= 16'h0100;
      tick(3);
      m.measured_voltage <= 16'h0100;
      tick(1);
      m.current <= 16'sh0100;
      m.measured_voltage <= 16'h1000;
      rchk(GA, 8'h54);
      if (i == 0) begin
        m.accumulated_charge <= 16'h0000;
      end else if (i == 1) begin
        m.current <= 16'sh0010;
      end else begin
        m.accumulated_charge_loaded <= 1'b1;
        tick(1);
        m.accumulated_charge_loaded <= 1'b0;
      end
      rchk(GA, 8'h44);
    end
    m.remaining_active_relative_capacity <= 8'h32;
    w(GA, 8'h00);
    rchk(GA, 8'h00);
  endtask : t_learn

  task automatic t_feature;
    w(SLAVE_ADDRESS_ADDR, 8'h50);
    check({1'b0, slave_address}, {1'b0, SLAVE_ADDRESS_RESET});
    w(FA, 8'hfc);
    gp_pu <= 1'b1;
    check({7'h0, gp_oe}, 8'h01);
    rchk(FA, 8'h00);
    w(FA, 8'h03);
    rchk(FA, 8'h03);
    gp_pu <= 1'b0;
    rchk(FA, 8'h02);
    w(SLAVE_ADDRESS_ADDR, 8'h50);
    check({1'b0, slave_address}, 8'h28);
    host.addr = 7'h28;
    rchk(FA, 8'h02);
    rchk(SLAVE_ADDRESS_ADDR, 8'h50);
  endtask : t_feature

  task automatic t_sleep;
    w(FA, 8'h00);
    w(PA, 8'h20);
    host.park();
    wait_sleep();
    check({7'h0, gp_oe}, 8'h00);
    host.unpark();
    check({7'h0, sleep}, 8'h00);
    w(PA, 8'h00);
    m.input_voltage <= 16'h0300;
    host.park();
    tick(3 * DLY);
    check({7'h0, sleep}, 8'h00);
    host.unpark();
    w(PA, 8'h40);
    wait_sleep();
    m.input_voltage <= 16'h1000;
    host.park();
    host.unpark();
    rchk(PA, 8'h40);
  endtask : t_sleep

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    m = '{16'h1000, 16'h2000, 16'h0200, 16'h0400, 16'h1000, 16'sh0000,
          16'sh0000, 16'sh0100, 16'sh0080, 8'h32, 8'h32, 16'h0100,
          1'b0, 1'b0};
    tick(16);
    rstn <= 1'b1;
    tick(2);
    t_reset();
    t_status();
    t_empty();
    t_full();
    t_learn();
    t_feature();
    t_sleep();
    tally_and_finish();
  end

  // the sequence needs well under half of this span
  initial begin
    #(300_000);
    err_count++;
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
